// >>> logic/snprc_regs.vh
`ifndef SNPRC_REGS_VH
`define SNPRC_REGS_VH

// Register offsets
`define SNPRC_RANGE_CFG_OFS 8'h1D
`define SNPRC_GC_SNAP_CODE 8'h1E
`define SNPRC_KEEP_SNAP_CODE 8'h1F
`define SNPRC_RATE_PIN_OFS 8'h20
`define SNPRC_RANGE_ACT_OFS 8'h22

// Reset values
`define SNPRC_RANGE_CFG_RST 16'h0000
`define SNPRC_RATE_PIN_RST 8'h00

// Rate-pin status/control bit positions
`define SNPRC_PIN_LEVEL_BIT 7
`define SNPRC_RISE_SEEN_BIT 6
`define SNPRC_FALL_SEEN_BIT 5
`define SNPRC_FULL_RISE_BIT 4
`define SNPRC_KEEP_RISE_BIT 3
`define SNPRC_FULL_FALL_BIT 2
`define SNPRC_KEEP_FALL_BIT 1

// Range field layout
`define SNPRC_SENSE_CH1_MSB 15
`define SNPRC_BUS_CH1_MSB 7
`define SNPRC_FIELD_W 2
`define SNPRC_CODE_UNIPOLAR 2'h0
`define SNPRC_CODE_BIPOLAR 2'h1
`define SNPRC_CODE_BIPOLAR_HALF 2'h2
`define SNPRC_CODE_RESERVED 2'h3

// Results settle time
`define SNPRC_SETTLE_US 1000
`define SNPRC_CLK_MHZ 250
`define SNPRC_SETTLE_CYC (`SNPRC_SETTLE_US * `SNPRC_CLK_MHZ)

`endif

// >>> logic/snprc_ctrl.v
// Function
// - Command 1E snapshots results, clears accumulators
// - Results ready within 1 ms, held
// - Command 1F snapshots, keeps accumulators
// - Bit 7 shows live override pin level
// - Bit 6 sets on rise, full or 1E snapshot clears
// - Bit 5 sets on fall, full or 1E snapshot clears
// - Bits 4/2 enable limited full snapshot
// - Bits 3/1 enable limited keep snapshot
// - Enable bits change only by writes
// - Limited snapshot leaves active settings alone
// - Limited full clears accumulators, keep does not
// - Both enabled on edge: full wins
// - Rate pin register acts immediately
// - Range settings activate only on snapshot
// - Override pin high forces 8 SPS
`include "snprc_regs.vh"

module snprc_ctrl #(
   parameter SETTLE_CYC = `SNPRC_SETTLE_CYC,
   parameter [7:0] FULL_SNAP_CODE = 8'h00
) (
   // Clock, reset, enable
   input wire clk,
   input wire sys_rst,
   input wire ce,
   // Register write from the serial front end
   input wire wr_en,
   input wire [7:0] wr_addr,
   input wire [15:0] wr_data,
   // Register read
   input wire rd_en,
   input wire [7:0] rd_addr,
   output reg [15:0] rd_data,
   // Send Byte command
   input wire cmd_valid,
   input wire [7:0] cmd_code,
   // Rate-override pin and its function select
   input wire rate_pin,
   input wire rate_pin_sel,
   // Strobes and levels to conversion engine
   output wire results_snap_p,
   output wire accum_clear_p,
   output wire activate_p,
   output reg results_ready,
   output reg [15:0] range_active,
   output wire force_8sps
);

   reg pin_prev_r;
   reg [3:0] edge_en_r;
   reg [31:0] settle_cnt_r;
   reg snap_r;
   reg clr_r;
   reg act_r;

   wire cmd_full;
   wire cmd_gc;
   wire cmd_keep;
   wire pin_rise;
   wire pin_fall;
   wire lim_full;
   wire lim_keep;
   wire any_snap;
   wire any_clear;
   wire any_act;
   wire [7:0] rate_reg;
   wire [15:0] range_cfg_q;
   wire [15:0] range_act_q;
   wire pin_sync;
   wire rise_seen;
   wire fall_seen;
   wire range_wr;
   wire flag_clear;

   localparam [15:0] RANGE_RST = `SNPRC_RANGE_CFG_RST;

   genvar gi;

   assign cmd_full = cmd_valid && cmd_code == FULL_SNAP_CODE;
   assign cmd_gc = cmd_valid && cmd_code == `SNPRC_GC_SNAP_CODE;
   assign cmd_keep = cmd_valid && cmd_code == `SNPRC_KEEP_SNAP_CODE;

   // Edge detect on the second synchroniser stage only
   assign pin_rise = pin_sync && !pin_prev_r;
   assign pin_fall = !pin_sync && pin_prev_r;

   // Full beats keep when both enabled for the same edge
   assign lim_full = (pin_rise && edge_en_r[3]) || (pin_fall && edge_en_r[1]);
   assign lim_keep = !lim_full &&
      ((pin_rise && edge_en_r[2]) || (pin_fall && edge_en_r[0]));

   assign any_snap = cmd_full || cmd_gc || cmd_keep || lim_full || lim_keep;
   assign any_clear = cmd_full || cmd_gc || lim_full;
   assign any_act = cmd_full || cmd_gc || cmd_keep;

   assign results_snap_p = snap_r;
   assign accum_clear_p = clr_r;
   assign activate_p = act_r;
   assign force_8sps = rate_pin_sel && pin_sync;

   assign rate_reg = {pin_sync, rise_seen, fall_seen, edge_en_r, 1'b0};

   assign range_wr = ce && wr_en && wr_addr == `SNPRC_RANGE_CFG_OFS;
   assign flag_clear = cmd_full || cmd_gc;

   // Two-stage synchroniser for the asynchronous pin
   snprc_sync2 u_pin_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .async_in(rate_pin),
      .sync_out(pin_sync)
   );

   // Edge history
   always @(posedge clk) begin
      if (sys_rst) begin
         pin_prev_r <= 1'b0;
      end else if (ce) begin
         pin_prev_r <= pin_sync;
      end
   end

   // Sticky edge flags, set wins over a same-cycle clear
   snprc_sticky u_rise_flag (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .set_ev(pin_rise),
      .clr_ev(flag_clear),
      .flag(rise_seen)
   );

   snprc_sticky u_fall_flag (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .set_ev(pin_fall),
      .clr_ev(flag_clear),
      .flag(fall_seen)
   );

   // Edge snapshot enables, changed only by writes
   always @(posedge clk) begin
      if (sys_rst) begin
         edge_en_r <= 4'h0;
      end else if (ce && wr_en && wr_addr == `SNPRC_RATE_PIN_OFS) begin
         edge_en_r <= wr_data[`SNPRC_FULL_RISE_BIT:`SNPRC_KEEP_FALL_BIT];
      end
   end

   // Programmed and active range fields, one per channel and quantity
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_field
         snprc_range_field #(
            .W(`SNPRC_FIELD_W),
            .RST(RANGE_RST[2 * gi + 1:2 * gi])
         ) u_field (
            .clk(clk),
            .sys_rst(sys_rst),
            .ce(ce),
            .wr_stb(range_wr),
            .wr_val(wr_data[2 * gi + 1:2 * gi]),
            .act_stb(any_act),
            .prog_q(range_cfg_q[2 * gi + 1:2 * gi]),
            .act_q(range_act_q[2 * gi + 1:2 * gi])
         );
      end
   endgenerate

   // Active image straight from the field flip-flops
   always @* begin
      range_active = range_act_q;
   end

   // Snapshot strobes
   always @(posedge clk) begin
      if (sys_rst) begin
         snap_r <= 1'b0;
         clr_r <= 1'b0;
         act_r <= 1'b0;
      end else if (ce) begin
         snap_r <= any_snap;
         clr_r <= any_clear;
         act_r <= any_act;
      end
   end

   // Results settle window after each snapshot
   always @(posedge clk) begin
      if (sys_rst) begin
         settle_cnt_r <= 32'h0;
         results_ready <= 1'b0;
      end else if (ce) begin
         if (any_snap) begin
            settle_cnt_r <= SETTLE_CYC[31:0];
            results_ready <= 1'b0;
         end else if (settle_cnt_r > 32'h1) begin
            settle_cnt_r <= settle_cnt_r - 32'h1;
         end else if (settle_cnt_r == 32'h1) begin
            settle_cnt_r <= 32'h0;
            results_ready <= 1'b1;
         end
      end
   end

   // Read data
   always @(posedge clk) begin
      if (sys_rst) begin
         rd_data <= 16'h0000;
      end else if (ce && rd_en) begin
         case (rd_addr)
            `SNPRC_RANGE_CFG_OFS: rd_data <= range_cfg_q;
            `SNPRC_RATE_PIN_OFS: rd_data <= {8'h00, rate_reg};
            `SNPRC_RANGE_ACT_OFS: rd_data <= range_active;
            default: rd_data <= 16'h0000;
         endcase
      end
   end

endmodule // snprc_ctrl

module snprc_sync2 (
   // Clock, reset, enable
   input wire clk,
   input wire sys_rst,
   input wire ce,
   // Pin in, synchronised level out
   input wire async_in,
   output wire sync_out
);

   reg meta_r;
   reg sync_r;

   assign sync_out = sync_r;

   // Only the second stage is read outside
   always @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else if (ce) begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

endmodule // snprc_sync2

module snprc_sticky (
   // Clock, reset, enable
   input wire clk,
   input wire sys_rst,
   input wire ce,
   // Events
   input wire set_ev,
   input wire clr_ev,
   // Flag
   output wire flag
);

   reg flag_r;

   assign flag = flag_r;

   // A new event is never lost to a same-cycle clear
   always @(posedge clk) begin
      if (sys_rst) begin
         flag_r <= 1'b0;
      end else if (ce) begin
         if (set_ev) begin
            flag_r <= 1'b1;
         end else if (clr_ev) begin
            flag_r <= 1'b0;
         end
      end
   end

endmodule // snprc_sticky

module snprc_range_field #(
   parameter W = 2,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   // Clock, reset, enable
   input wire clk,
   input wire sys_rst,
   input wire ce,
   // Programming and activation
   input wire wr_stb,
   input wire [W-1:0] wr_val,
   input wire act_stb,
   // Programmed and active codes
   output wire [W-1:0] prog_q,
   output wire [W-1:0] act_q
);

   reg [W-1:0] prog_r;
   reg [W-1:0] act_r;

   assign prog_q = prog_r;
   assign act_q = act_r;

   // Reserved codes kept as written; activation copies the old code on a same-cycle write
   always @(posedge clk) begin
      if (sys_rst) begin
         prog_r <= RST;
         act_r <= RST;
      end else if (ce) begin
         if (wr_stb) begin
            prog_r <= wr_val;
         end
         if (act_stb) begin
            act_r <= prog_r;
         end
      end
   end

endmodule // snprc_range_field

// >>> verification/snprc_ctrl_assertions.sv
module snprc_chk #(parameter SETTLE_CYC = 20, parameter [7:0] FULL_SNAP_CODE = 8'h00) (
   input wire clk, sys_rst, ce, wr_en, rd_en, cmd_valid, rate_pin, rate_pin_sel,
   input wire [7:0] wr_addr, rd_addr, cmd_code,
   input wire [15:0] wr_data, rd_data, range_active,
   input wire results_snap_p, accum_clear_p, activate_p, results_ready, force_8sps
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence pin_high3;
      (ce && rate_pin_sel && rate_pin) [*3];
   endsequence
   sequence pin_low3;
      (ce && rate_pin_sel && !rate_pin) [*3];
   endsequence
   a_full_snap:
      assert property (ce && cmd_valid && cmd_code == FULL_SNAP_CODE |=>
         results_snap_p && accum_clear_p && activate_p) else $error("full snapshot");
   a_force_release:
      assert property (pin_low3 |-> !force_8sps) else $error("rate still forced");
   a_ready_hold:
      assert property ($past(results_ready) && !results_snap_p |-> results_ready)
         else $error("ready dropped without snapshot");
   a_gc_snap:
      assert property (ce && cmd_valid && cmd_code == 8'h1E |=>
         results_snap_p && accum_clear_p && activate_p) else $error("general snapshot");
   a_keep_snap:
      assert property (ce && cmd_valid && cmd_code == 8'h1F |=>
         results_snap_p && activate_p && !accum_clear_p) else $error("keep snapshot");
   a_active_hold:
      assert property (!activate_p |-> $stable(range_active)) else $error("active range moved");
   a_ready_drop:
      assert property (results_snap_p |-> !results_ready) else $error("ready not dropped");
   a_force_rate:
      assert property (pin_high3 |-> force_8sps) else $error("rate not forced");
   a_status_zero:
      assert property (ce && rd_en && rd_addr == 8'h20 |=>
         rd_data[15:8] == 8'h00 && !rd_data[0]) else $error("status spare bits");
   a_clear_snap:
      assert property (accum_clear_p |-> results_snap_p) else $error("clear without snap");
   a_act_cmd:
      assert property (activate_p && $past(ce) |-> $past(cmd_valid)) else $error("stray activate");
endmodule // snprc_chk

bind snprc_ctrl snprc_chk #(.SETTLE_CYC(SETTLE_CYC), .FULL_SNAP_CODE(FULL_SNAP_CODE)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .ce(ce), .wr_en(wr_en), .rd_en(rd_en), .cmd_valid(cmd_valid),
   .rate_pin(rate_pin), .rate_pin_sel(rate_pin_sel), .wr_addr(wr_addr), .rd_addr(rd_addr),
   .cmd_code(cmd_code), .wr_data(wr_data), .rd_data(rd_data), .range_active(range_active),
   .results_snap_p(results_snap_p), .accum_clear_p(accum_clear_p), .activate_p(activate_p),
   .results_ready(results_ready), .force_8sps(force_8sps));

// >>> verification/snprc_host_model.sv
module snprc_host_model (
   input wire clk, go,
   input wire [7:0] code,
   output logic cmd_valid = 1'b0,
   output logic [7:0] cmd_code = 8'hFF
);
   timeunit 1ns;
   timeprecision 1ps;
   // Send Byte as one-cycle pulse; idle code toggles
   always @(posedge clk) begin
      cmd_valid <= go;
      cmd_code <= go ? code : ~cmd_code;
   end
endmodule // snprc_host_model

// >>> verification/snprc_ctrl_tb_top.sv
module snprc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, sys_rst = 1, wr_en = 0, rd_en = 0, rate_pin = 0, go = 0;
   logic [7:0] wr_addr = '0, rd_addr = '0, code = '0, cmd_code;
   logic [15:0] wr_data = '0, rd_data, range_active;
   logic cmd_valid, snap, clr, act, rdy, f8;
   logic ce = 1, sel = 1;
   int fail_count = 0, n_checks = 0, n_snap = 0, n_clr = 0, n_act = 0;
   logic [39:0] rows [4] = '{40'h1D_A5C3_A5C3, 40'h1D_FFFF_FFFF, 40'h20_FFFF_001E, 40'h30_1234_0000};
   initial forever #2 clk = ~clk;
   snprc_host_model host (.clk(clk), .go(go), .code(code), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code));
   snprc_ctrl #(.SETTLE_CYC(20)) dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rate_pin(rate_pin), .rate_pin_sel(sel),
      .results_snap_p(snap), .accum_clear_p(clr), .activate_p(act), .results_ready(rdy),
      .range_active(range_active), .force_8sps(f8));
   always @(posedge clk) begin
      if (!sys_rst) begin
         n_snap += snap;
         n_clr += clr;
         n_act += act;
      end
   end
   task automatic summarize;
      if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cnt(input logic [15:0] e);
      chk("strobes", {4'h0, n_snap[3:0], n_clr[3:0], n_act[3:0]}, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      wr_en <= 1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clk) wr_en <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      rd_en <= 1;
      rd_addr <= a;
      @(posedge clk) rd_en <= 0;
      @(posedge clk) chk("rd_data", rd_data, e);
   endtask
   task automatic cmd(input logic [7:0] c);
      go <= 1;
      code <= c;
      @(posedge clk) go <= 0;
      repeat (3) @(posedge clk);
   endtask
   task automatic pin(input logic v);
      rate_pin <= v;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      rd(8'h1D, '0);
      rd(8'h20, '0);
      foreach (rows[i]) begin
         wr(rows[i][39:32], rows[i][31:16]);
         rd(rows[i][39:32], rows[i][15:0]);
      end
      chk("active", range_active, '0);
      cmd(8'h1E);
      chk("active", range_active, 16'hFFFF);
      cnt(16'h0111);
      for (int i = 0; rdy !== 1'b1; i++) begin
         if (i > 100) begin
            fail_count++;
            summarize();
         end
         @(posedge clk);
      end
      wr(8'h20, 16'h0018);
      pin(1);
      chk("force", {15'h0, f8}, 16'h0001);
      cnt(16'h0221);
      rd(8'h20, 16'h00D8);
      wr(8'h1D, '0);
      wr(8'h20, 16'h0002);
      pin(0);
      chk("force", {15'h0, f8}, 16'h0000);
      cnt(16'h0321);
      chk("active", range_active, 16'hFFFF);
      rd(8'h20, 16'h0062);
      cmd(8'h1F);
      cnt(16'h0422);
      chk("active", range_active, '0);
      rd(8'h20, 16'h0062);
      cmd(8'h1E);
      rd(8'h20, 16'h0002);
      cnt(16'h0533);
      chk("ready", {15'h0, rdy}, 16'h0000);
      sel <= 0;
      pin(1);
      chk("force", {15'h0, f8}, 16'h0000);
      cnt(16'h0533);
      sel <= 1;
      @(posedge clk);
      chk("force", {15'h0, f8}, 16'h0001);
      cmd(8'h00);
      cnt(16'h0644);
      rd(8'h20, 16'h0082);
      ce <= 0;
      cmd(8'h1E);
      ce <= 1;
      cnt(16'h0644);
      sys_rst <= 1;
      repeat (2) @(posedge clk);
      chk("rst force", {15'h0, f8}, 16'h0000);
      chk("rst rd_data", rd_data, 16'h0000);
      sys_rst <= 0;
      repeat (5) @(posedge clk);
      rd(8'h20, 16'h00C0);
      cnt(16'h0644);
      summarize();
   end
endmodule // snprc_ctrl_tb_top
